// file: dv/jog_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// keypad and drive-condition model
// ----------------------------------------
module jog_partner (
   // clock
   input  wire logic             CLK,
   // pins towards the sequencer
   output pjog_pkg::keypad_t     KEYS,
   output pjog_pkg::drive_cond_t COND
);
   // keys released, power on, no fault
   initial begin
      KEYS = '0;
      COND = 5'h10;
   end
   // hold a key past the pin synchroniser, then let go
   task automatic press(input int k);
      @(posedge CLK);
      KEYS[k] <= 1'b1;
      repeat (6) @(posedge CLK);
      KEYS[k] <= 1'b0;
   endtask : press
   // change drive condition levels
   task automatic set_cond(input logic [4:0] c);
      @(posedge CLK);
      COND <= c;
   endtask : set_cond
endmodule : jog_partner

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
   logic                  CLK = 1'b0;
   logic                  RST = 1'b1;
   logic [7:0]            AWADDR = 8'h00;
   logic [7:0]            ARADDR = 8'h00;
   logic [31:0]           WDATA = 32'h0;
   logic [3:0]            WSTRB = 4'hF;
   logic                  AWVALID = 1'b0;
   logic                  WVALID = 1'b0;
   logic                  BREADY = 1'b0;
   logic                  ARVALID = 1'b0;
   logic                  RREADY = 1'b0;
   logic                  DIR_SELECT = 1'b0;
   logic                  DD_MOTOR = 1'b0;
   logic                  AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [1:0]            BRESP, RRESP;
   logic [31:0]           RDATA, rd;
   logic [1:0]            rs;
   logic                  SERVO_POWER, MOTION_CCW, END_SHOW;
   logic [16:0]           MOTION_SPEED;
   pjog_pkg::keypad_t     KEYS;
   pjog_pkg::drive_cond_t COND;
   int                    miscompares = 0;
   int                    checked = 0;
   always #25 CLK = ~CLK;
   // short ms so long counts stay cheap
   pattern_jog_sequencer #(.CYC_PER_MS(20)) dut_u (.CLK(CLK), .RST(RST),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
      .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .COND(COND), .KEYS(KEYS), .DIR_SELECT(DIR_SELECT),
      .DD_MOTOR(DD_MOTOR), .SERVO_POWER(SERVO_POWER), .MOTION_CCW(MOTION_CCW),
      .MOTION_SPEED(MOTION_SPEED), .END_SHOW(END_SHOW));
   jog_partner pm_u (.CLK(CLK), .KEYS(KEYS), .COND(COND));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // write: ready read just after an edge is the value that edge saw
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      logic b;
      int   n;
      n = 0;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= s;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
         b = BVALID && BREADY;
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
      end while (!b && n < 50);
      BREADY <= 1'b0;
      chk("write answer", 32'h1, 32'(b));
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic v;
      int   n;
      n = 0;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
         v = RVALID && RREADY;
         d = RDATA;
         r = RRESP;
         if (ARVALID && ARREADY) ARVALID <= 1'b0;
      end while (!v && n < 50);
      RREADY <= 1'b0;
      chk("read answer", 32'h1, 32'(v));
   endtask : axr
   // defaults, range drops, unmapped read
   task automatic t_regs();
      logic [31:0] dv [6] = '{32'h0, 32'h8000, 32'h1F4, 32'h64, 32'h64, 32'h1};
      for (int i = 0; i < 6; i++) begin
         axr(8'(i * 4 + 4), rd, rs);
         chk("default", dv[i], rd);
      end
      axw(8'h18, 32'h3E9);
      axr(8'h18, rd, rs);
      chk("repeat range", 32'h1, rd);
      axw(8'h04, 32'h6);
      axr(8'h04, rd, rs);
      chk("pattern range", 32'h0, rd);
      axw(8'h08, 32'hFFFF_FF10, 4'h1);
      axr(8'h08, rd, rs);
      chk("strobe merge", 32'h0000_8010, rd);
      axr(8'h20, rd, rs);
      chk("unmapped resp", 32'h2, 32'(rs));
   endtask : t_regs
   // each blocking condition keeps power off
   task automatic t_refuse();
      logic [4:0] bad [6] = '{5'h10, 5'h00, 5'h18, 5'h14, 5'h12, 5'h11};
      for (int i = 0; i < 6; i++) begin
         axw(8'h00, (i == 0) ? 32'h1 : 32'h0);
         pm_u.set_cond(bad[i]);
         pm_u.press(2);
         repeat (8) @(posedge CLK);
         chk("refused start", 32'h0, 32'(SERVO_POWER));
      end
      pm_u.set_cond(5'h10);
   endtask : t_refuse
   // full pattern: dwell, peak speed, direction, end display, move count
   task automatic t_run(input logic [2:0] pat, input logic [9:0] rep, input logic dd,
                        input logic dir, input logic [16:0] pk, input logic ccw);
      int          n, first, e;
      logic [16:0] top;
      logic        cw_seen;
      logic        flip;
      axw(8'h04, 32'(pat));
      axw(8'h08, 32'd100);
      axw(8'h0C, 32'd5);
      axw(8'h10, 32'd2);
      axw(8'h14, 32'd5);
      axw(8'h18, 32'(rep));
      DD_MOTOR <= dd;
      DIR_SELECT <= dir;
      pm_u.press(2);
      repeat (8) @(posedge CLK);
      chk("power on", 32'h1, 32'(SERVO_POWER));
      pm_u.press(1);
      n = 0;
      first = 0;
      top = '0;
      cw_seen = 1'b0;
      flip = 1'b0;
      while (END_SHOW !== 1'b1 && n < 8000) begin
         @(negedge CLK);
         n++;
         if (MOTION_SPEED !== 17'h0 && first == 0) first = n;
         if (MOTION_SPEED > top) top = MOTION_SPEED;
         if (first != 0 && first + 5 == n) cw_seen = MOTION_CCW;
         if (first != 0 && n > first + 5 && MOTION_CCW !== cw_seen) flip = 1'b1;
      end
      chk("alternate", 32'(pat[0] && rep > 10'h1), 32'(flip));
      chk("dwell first", 32'h1, 32'(first >= 100));
      chk("peak speed", 32'(pk), 32'(top));
      chk("direction", 32'(ccw), 32'(cw_seen));
      e = 0;
      while (END_SHOW === 1'b1 && e < 21000) begin
         @(negedge CLK);
         e++;
      end
      chk("end one s", 32'h1, 32'(e >= 19980 && e <= 20040));
      axr(8'h1C, rd, rs);
      chk("moves done", (rep == 0) ? 32'h1 : 32'(rep), 32'(rd[15:6]));
      pm_u.press(2);
      repeat (8) @(posedge CLK);
   endtask : t_run
   // endless run stopped by the servo key
   task automatic t_abort();
      int n;
      axw(8'h04, 32'h0);
      axw(8'h18, 32'h0);
      pm_u.press(2);
      pm_u.press(0);
      n = 0;
      while (MOTION_SPEED === 17'h0 && n < 2000) begin
         @(negedge CLK);
         n++;
      end
      repeat (3000) @(posedge CLK);
      chk("endless run", 32'h1, 32'(SERVO_POWER));
      chk("reverse dir", 32'h1, 32'(MOTION_CCW));
      axr(8'h1C, rd, rs);
      chk("endless moves", 32'h1, 32'(rd[15:6] > 10'h1));
      pm_u.press(2);
      chk("abort power", 32'h0, 32'(SERVO_POWER));
      chk("abort speed", 32'h0, 32'(MOTION_SPEED));
   endtask : t_abort
   task automatic conclude();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   // main sequence
   initial begin
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      t_regs();
      t_refuse();
      t_run(3'h1, 10'h2, 1'b0, 1'b0, 17'h00032, 1'b1);
      t_run(3'h2, 10'h0, 1'b1, 1'b1, 17'd5, 1'b0);
      t_abort();
      conclude();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge CLK);
      miscompares++;
      conclude();
   end
endmodule : tb

// file: hdl/pattern_jog_sequencer.sv
`timescale 1ns/1ps
`include "pjog_consts.svh"
// Operation
// - start only when writes are permitted
// - need main power on, no alarm
// - base-block input blocks operation
// - enter only from motor power off
// - overtravel stays armed, blocks start
// - run pattern with all configured settings
// - repeat count zero repeats endlessly
// - pattern digit 2 or 3: no endless
// - pattern select 0 to 5, default 0
// - distance, speed, dwell, ramp range checks
// - repeat count 0 to 1000, default 1
// - direct-drive speed counts in 0.1 steps
// - forward sense follows direction select
// - dwell before first move, end one second
module pattern_jog_sequencer #(
   parameter int CYC_PER_MS = `CYC_PER_MS
) (
   // clock and reset
   input  wire logic                CLK,
   input  wire logic                RST,
   // axi4-lite write
   input  wire logic [7:0]          AWADDR,
   input  wire logic                AWVALID,
   output logic                     AWREADY,
   input  wire logic [31:0]         WDATA,
   input  wire logic [3:0]          WSTRB,
   input  wire logic                WVALID,
   output logic                     WREADY,
   output logic [1:0]               BRESP,
   output logic                     BVALID,
   input  wire logic                BREADY,
   // axi4-lite read
   input  wire logic [7:0]          ARADDR,
   input  wire logic                ARVALID,
   output logic                     ARREADY,
   output logic [31:0]              RDATA,
   output logic [1:0]               RRESP,
   output logic                     RVALID,
   input  wire logic                RREADY,
   // pins from drive and keypad
   input  wire pjog_pkg::drive_cond_t COND,
   input  wire pjog_pkg::keypad_t   KEYS,
   input  wire logic                DIR_SELECT,
   input  wire logic                DD_MOTOR,
   // to position loop and display
   output logic                     SERVO_POWER,
   output logic                     MOTION_CCW,
   output logic [16:0]              MOTION_SPEED,
   output logic                     END_SHOW
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [9:0] meta_q;  // first stage, read only by sync_q
   logic [9:0] sync_q;
   logic [2:0] key_prev_q;
   pjog_pkg::drive_cond_t cond;
   pjog_pkg::keypad_t     key, key_rise;
   logic dir_sel, dd;

   always_ff @(posedge CLK) begin
      if (RST) begin
         meta_q     <= 10'h0;
         sync_q     <= 10'h0;
         key_prev_q <= 3'h0;
      end else begin
         meta_q     <= {COND, KEYS, DIR_SELECT, DD_MOTOR};
         sync_q     <= meta_q;
         key_prev_q <= sync_q[4:2];
      end
   end

   assign cond     = sync_q[9:5];
   assign key      = sync_q[4:2];
   assign dir_sel  = sync_q[1];
   assign dd       = sync_q[0];
   assign key_rise = key & ~key_prev_q;

   // ----------------------------------------
   // register file and bus slave
   // ----------------------------------------
   pjog_pkg::jog_cfg_t cfg_q, cfg_d;
   logic [15:0] wp_q, wp_d;          // write-protect setting
   logic        aw_q, aw_d;          // write address held
   logic [7:0]  awa_q, awa_d;
   logic        w_q, w_d;            // write data held
   logic [31:0] wd_q, wd_d;
   logic [3:0]  ws_q, ws_d;
   logic        bv_q, bv_d;
   logic [1:0]  br_q, br_d;
   logic        rv_q, rv_d;
   logic [31:0] rd_q, rd_d;
   logic [1:0]  rr_q, rr_d;
   logic [31:0] wv, rv_word;         // merged write word, current read word
   logic        hit;
   pjog_pkg::seq_state_t st_q, st_d;
   logic [9:0]  done_q, done_d;      // moves finished this run
   logic [13:0] vel;

   // merge a write word under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction : merge

   // read mux for a given offset
   function automatic logic [32:0] rmux(input logic [7:0] a);
      unique case (a)
         `OFS_WPROT:   rmux = {1'b1, 16'h0, wp_q};
         `OFS_PATTERN: rmux = {1'b1, 29'h0, cfg_q.pattern};
         `OFS_DIST:    rmux = {1'b1, 1'b0, cfg_q.distance};
         `OFS_SPEED:   rmux = {1'b1, 18'h0, cfg_q.speed};
         `OFS_RAMP:    rmux = {1'b1, 18'h0, cfg_q.ramp};
         `OFS_DWELL:   rmux = {1'b1, 18'h0, cfg_q.dwell};
         `OFS_REPEAT:  rmux = {1'b1, 22'h0, cfg_q.repeats};
         `OFS_STATUS:  rmux = {1'b1, 16'h0, done_q, 3'(st_q), SERVO_POWER, END_SHOW, dd};
         default:      rmux = {1'b0, 32'h0};
      endcase
   endfunction : rmux

   assign AWREADY = !aw_q && !bv_q;
   assign WREADY  = !w_q && !bv_q;
   assign ARREADY = !rv_q;

   // bus handshakes and range-checked register writes
   always_comb begin
      aw_d  = aw_q;
      awa_d = awa_q;
      w_d   = w_q;
      wd_d  = wd_q;
      ws_d  = ws_q;
      bv_d  = bv_q;
      br_d  = br_q;
      rv_d  = rv_q;
      rd_d  = rd_q;
      rr_d  = rr_q;
      cfg_d = cfg_q;
      wp_d  = wp_q;
      if (AWVALID && AWREADY) begin
         aw_d  = 1'b1;
         awa_d = AWADDR;
      end
      if (WVALID && WREADY) begin
         w_d  = 1'b1;
         wd_d = WDATA;
         ws_d = WSTRB;
      end
      if (BVALID && BREADY) bv_d = 1'b0;
      {hit, rv_word} = rmux(awa_q);
      wv = merge(rv_word, wd_q, ws_q);
      if (aw_q && w_q) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = hit ? 2'b00 : 2'b10;
         // out-of-range values are dropped, old setting stays
         unique case (awa_q)
            `OFS_WPROT: wp_d = wv[15:0];
            // selector 0 to 5, live at once
            `OFS_PATTERN: if (wv <= 32'(`PATTERN_MAX)) cfg_d.pattern = wv[2:0];
            `OFS_DIST: if (wv >= 32'(`DIST_MIN) && wv <= 32'(`DIST_MAX))
                          cfg_d.distance = wv[30:0];
            `OFS_SPEED: if (wv >= 32'(`SPEED_MIN) && wv <= 32'(`SPEED_MAX))
                          cfg_d.speed = wv[13:0];
            `OFS_RAMP: if (wv >= 32'(`RAMP_MIN) && wv <= 32'(`RAMP_MAX))
                          cfg_d.ramp = wv[13:0];
            `OFS_DWELL: if (wv <= 32'(`DWELL_MAX)) cfg_d.dwell = wv[13:0];
            `OFS_REPEAT: if (wv <= 32'(`REPEAT_MAX)) cfg_d.repeats = wv[9:0];
            default: ;
         endcase
      end
      if (RVALID && RREADY) rv_d = 1'b0;
      if (ARVALID && ARREADY) begin
         rv_d = 1'b1;
         {hit, rd_d} = rmux(ARADDR);
         rr_d = hit ? 2'b00 : 2'b10;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         cfg_q <= '{`PATTERN_RST, `DIST_RST, `SPEED_RST, `RAMP_RST, `DWELL_RST, `REPEAT_RST};
         wp_q  <= `WPROT_RST;
         aw_q  <= 1'b0;
         awa_q <= 8'h00;
         w_q   <= 1'b0;
         wd_q  <= 32'h0;
         ws_q  <= 4'h0;
         bv_q  <= 1'b0;
         br_q  <= 2'b00;
         rv_q  <= 1'b0;
         rd_q  <= 32'h0;
         rr_q  <= 2'b00;
      end else begin
         cfg_q <= cfg_d;
         wp_q  <= wp_d;
         aw_q  <= aw_d;
         awa_q <= awa_d;
         w_q   <= w_d;
         wd_q  <= wd_d;
         ws_q  <= ws_d;
         bv_q  <= bv_d;
         br_q  <= br_d;
         rv_q  <= rv_d;
         rd_q  <= rd_d;
         rr_q  <= rr_d;
      end
   end

   assign BVALID = bv_q;
   assign BRESP  = br_q;
   assign RVALID = rv_q;
   assign RDATA  = rd_q;
   assign RRESP  = rr_q;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   logic        tick, start, prof_done;
   logic [13:0] tmr_q, tmr_d;   // dwell or end-show ms left
   logic        fwd_q, fwd_d;   // current move in forward sense
   logic        start_ok, abort, endless;
   logic [9:0]  reps;           // effective move count

   pjog_tick #(.CYCLES(CYC_PER_MS)) u_tick (.clk(CLK), .rst(RST), .tick(tick));

   always_comb begin
      start_ok = (wp_q == `WPROT_PERMIT) && cond.main_power && !cond.alarm
                 && !cond.base_block && !cond.ot_fwd && !cond.ot_rev;
      // any of these drops power mid-run
      abort = key_rise.servo_on || !cond.main_power || cond.alarm || cond.base_block
              || cond.ot_fwd || cond.ot_rev;
      // zero count is endless unless pattern digit is 2 or 3
      endless = (cfg_q.repeats == 10'h0) && !(cfg_q.pattern == 3'h2 || cfg_q.pattern == 3'h3);
      reps  = (cfg_q.repeats == 10'h0) ? 10'h001 : cfg_q.repeats;
      st_d  = st_q;
      tmr_d = tmr_q;
      fwd_d = fwd_q;
      done_d = done_q;
      start = 1'b0;
      unique case (st_q)
         // power-up only from the base-blocked state
         pjog_pkg::ST_OFF: if (key_rise.servo_on && start_ok) st_d = pjog_pkg::ST_ARMED;
         pjog_pkg::ST_ARMED: begin
            if (abort) st_d = pjog_pkg::ST_OFF;
            else if (key_rise.fwd || key_rise.rev) begin
               st_d   = pjog_pkg::ST_DWELL;
               tmr_d  = cfg_q.dwell;
               fwd_d  = key_rise.fwd;
               done_d = 10'h0;
            end
         end
         pjog_pkg::ST_DWELL: begin
            if (abort) st_d = pjog_pkg::ST_OFF;
            else if (tick && tmr_q == 14'h0) begin
               st_d  = pjog_pkg::ST_MOVE;
               start = 1'b1;
            end else if (tick) tmr_d = tmr_q - 14'h1;
         end
         pjog_pkg::ST_MOVE: begin
            if (abort) st_d = pjog_pkg::ST_OFF;
            else if (prof_done) begin
               // count moves, odd patterns swap direction each move
               done_d = done_q + 10'h1;
               if (!endless && done_q + 10'h1 >= reps) begin
                  st_d  = pjog_pkg::ST_END;
                  tmr_d = `END_SHOW_MS - 14'h1;
               end else begin
                  st_d  = pjog_pkg::ST_DWELL;
                  tmr_d = cfg_q.dwell;
                  fwd_d = fwd_q ^ cfg_q.pattern[0];
               end
            end
         end
         pjog_pkg::ST_END: begin
            if (abort) st_d = pjog_pkg::ST_OFF;
            else if (tick && tmr_q == 14'h0) st_d = pjog_pkg::ST_ARMED;
            else if (tick) tmr_d = tmr_q - 14'h1;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q   <= pjog_pkg::ST_OFF;
         tmr_q  <= 14'h0;
         fwd_q  <= 1'b1;
         done_q <= 10'h0;
      end else begin
         st_q   <= st_d;
         tmr_q  <= tmr_d;
         fwd_q  <= fwd_d;
         done_q <= done_d;
      end
   end

   pjog_profile u_prof (
      .clk(CLK), .rst(RST), .start(start), .abort(st_d == pjog_pkg::ST_OFF),
      .tick(tick), .distance(cfg_q.distance), .top(cfg_q.speed), .ramp(cfg_q.ramp),
      .busy(), .done(prof_done), .vel(vel));

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   logic [16:0] spd_q, spd_d;   // speed in 0.1 per minute
   logic        ccw_q, ccw_d;

   always_comb begin
      // direct-drive speed already counts in tenths
      spd_d = dd ? 17'(vel) : 17'(vel) * 17'h0000A;
      ccw_d = fwd_q ^ dir_sel;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         spd_q <= 17'h0;
         ccw_q <= 1'b0;
      end else begin
         spd_q <= spd_d;
         ccw_q <= ccw_d;
      end
   end

   assign SERVO_POWER  = (st_q != pjog_pkg::ST_OFF);
   assign END_SHOW     = (st_q == pjog_pkg::ST_END);
   assign MOTION_SPEED = spd_q;
   assign MOTION_CCW   = ccw_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_dwell_out;
      st_q == pjog_pkg::ST_DWELL && tick && tmr_q == 14'h0 && !abort;
   endsequence
   a_start_permit: assert property ($rose(SERVO_POWER) |-> $past(wp_q) == `WPROT_PERMIT)
      else $error("powered up with writes prohibited");
   a_start_power: assert property ($rose(SERVO_POWER) |-> $past(cond.main_power && !cond.alarm))
      else $error("powered up without main power or with alarm");
   a_base_block: assert property (cond.base_block |=> !SERVO_POWER)
      else $error("power kept during base-block");
   a_entry_off: assert property ($rose(st_q == pjog_pkg::ST_ARMED) && $past(st_q) != pjog_pkg::ST_END |-> $past(st_q) == pjog_pkg::ST_OFF)
      else $error("entry not from base-blocked state");
   a_overtravel: assert property ((cond.ot_fwd || cond.ot_rev) |=> !SERVO_POWER)
      else $error("running on overtravel");
   a_dwell_move: assert property (s_dwell_out |=> st_q == pjog_pkg::ST_MOVE ##0 u_prof.busy)
      else $error("move did not follow dwell");
   a_finite_end: assert property (st_q == pjog_pkg::ST_MOVE && prof_done && !abort && !endless && done_q + 10'h1 >= reps |=> END_SHOW)
      else $error("finite run did not end");
   a_no_endless: assert property (cfg_q.pattern[2:1] == 2'h1 && cfg_q.repeats == 10'h0
      && st_q == pjog_pkg::ST_MOVE && prof_done && !abort |=> END_SHOW)
      else $error("endless run in pattern 2 or 3");
   a_cfg_range: assert property (cfg_q.pattern <= `PATTERN_MAX && cfg_q.repeats <= `REPEAT_MAX && cfg_q.speed >= `SPEED_MIN)
      else $error("setting out of range");
   a_key_abort: assert property (key_rise.servo_on && SERVO_POWER |=> !SERVO_POWER ##1 MOTION_SPEED == 17'h0)
      else $error("servo key did not abort");
endmodule : pattern_jog_sequencer

// file: hdl/pjog_consts.svh
`ifndef PJOG_CONSTS_SVH
`define PJOG_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_WPROT   8'h00
`define OFS_PATTERN 8'h04
`define OFS_DIST    8'h08
`define OFS_SPEED   8'h0C
`define OFS_RAMP    8'h10
`define OFS_DWELL   8'h14
`define OFS_REPEAT  8'h18
`define OFS_STATUS  8'h1C
// ----------------------------------------
// reset values and legal ranges
// ----------------------------------------
`define WPROT_PERMIT 16'h0000
`define WPROT_RST    16'h0000
`define PATTERN_RST  3'h0
`define PATTERN_MAX  3'h5
`define DIST_RST     31'h0000_8000
`define DIST_MIN     31'h0000_0001
`define DIST_MAX     31'h4000_0000
`define SPEED_RST    14'h01F4
`define SPEED_MIN    14'h0001
`define SPEED_MAX    14'h2710
`define RAMP_RST     14'h0064
`define RAMP_MIN     14'h0002
`define RAMP_MAX     14'h2710
`define DWELL_RST    14'h0064
`define DWELL_MAX    14'h2710
`define REPEAT_RST   10'h001
`define REPEAT_MAX   10'h3E8
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define MS_NS         1000000
`define CYC_PER_MS    (`MS_NS / `CLK_PERIOD_NS)
`define END_SHOW_MS   14'h03E8
`endif

// file: hdl/pjog_pkg.sv
package pjog_pkg;
   // sequencer states
   typedef enum logic [2:0] {ST_OFF, ST_ARMED, ST_DWELL, ST_MOVE, ST_END} seq_state_t;
   // pattern settings as software holds them
   typedef struct packed {
      logic [2:0]  pattern;
      logic [30:0] distance;
      logic [13:0] speed;
      logic [13:0] ramp;
      logic [13:0] dwell;
      logic [9:0]  repeats;
   } jog_cfg_t;
   // drive condition pins
   typedef struct packed {
      logic main_power;
      logic alarm;
      logic base_block;
      logic ot_fwd;
      logic ot_rev;
   } drive_cond_t;
   // operator keypad
   typedef struct packed {
      logic servo_on;
      logic fwd;
      logic rev;
   } keypad_t;
endpackage : pjog_pkg

// file: hdl/pjog_profile.sv
`timescale 1ns/1ps
// trapezoid move generator, one step per ms tick
module pjog_profile (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // control
   input  wire logic        start,
   input  wire logic        abort,
   input  wire logic        tick,
   input  wire logic [30:0] distance,
   input  wire logic [13:0] top,
   input  wire logic [13:0] ramp,
   // status
   output logic             busy,
   output logic             done,
   output logic [13:0]      vel
);
   logic        busy_q, busy_d;   // move under way
   logic        dec_q, dec_d;     // decelerating
   logic [13:0] vel_q, vel_d;     // units per tick
   logic [30:0] trav_q, trav_d;   // distance covered
   logic [30:0] acc_q, acc_d;     // distance spent ramping up
   logic [13:0] step;             // speed change per tick
   logic [30:0] rem;
   logic [14:0] vup;
   logic [13:0] vn;
   logic [30:0] mv;

   // ----------------------------------------
   // profile step
   // ----------------------------------------
   always_comb begin
      step   = ((top / ramp) == 14'h0) ? 14'h0001 : top / ramp;
      rem    = distance - trav_q;
      vup    = {1'b0, vel_q} + {1'b0, step};
      busy_d = busy_q;
      dec_d  = dec_q;
      trav_d = trav_q;
      acc_d  = acc_q;
      vel_d  = vel_q;
      vn     = vel_q;
      mv     = 31'h0;
      done   = 1'b0;
      if (start) begin
         busy_d = 1'b1;
         dec_d  = 1'b0;
         trav_d = 31'h0;
         acc_d  = 31'h0;
         vel_d  = 14'h0;
      end else if (abort) begin
         busy_d = 1'b0;
         vel_d  = 14'h0;
      end else if (busy_q && tick) begin
         // ramp down once the rest fits the braking run
         if (dec_q || rem <= acc_q + 31'(vel_q)) begin
            dec_d = 1'b1;
            vn    = (vel_q > step) ? vel_q - step : 14'h0001;
         end else begin
            vn = (vup > {1'b0, top}) ? top : vup[13:0];
         end
         // last step is trimmed so the move ends on the exact distance
         mv     = (31'(vn) > rem) ? rem : 31'(vn);
         trav_d = trav_q + mv;
         // only the climb counts, so the cruise is not cut short at mid-distance
         if (!dec_d && vel_q < top) acc_d = acc_q + mv;
         vel_d  = vn;
         if (mv == rem) begin
            busy_d = 1'b0;
            vel_d  = 14'h0;
            done   = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_q <= 1'b0;
         dec_q  <= 1'b0;
         vel_q  <= 14'h0;
         trav_q <= 31'h0;
         acc_q  <= 31'h0;
      end else begin
         busy_q <= busy_d;
         dec_q  <= dec_d;
         vel_q  <= vel_d;
         trav_q <= trav_d;
         acc_q  <= acc_d;
      end
   end

   assign busy = busy_q;
   assign vel  = vel_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_move_exact_len: assert property (done |=> trav_q == distance)
      else $error("move did not end on the set distance");
   a_speed_capped: assert property (busy_q |-> vel_q <= top)
      else $error("speed above set speed");
endmodule : pjog_profile

// file: hdl/pjog_tick.sv
`timescale 1ns/1ps
// one-cycle enable every CYCLES clocks
module pjog_tick #(
   parameter int CYCLES = 20000
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // enable out
   output logic      tick
);
   logic [31:0] cnt_q; // cycles left to next tick
   logic [31:0] cnt_d;

   // ----------------------------------------
   // divider
   // ----------------------------------------
   always_comb begin
      cnt_d = (cnt_q == 32'h0) ? 32'(CYCLES - 1) : cnt_q - 32'h1;
   end

   always_ff @(posedge clk) begin
      if (rst) cnt_q <= 32'h0;
      else     cnt_q <= cnt_d;
   end

   assign tick = (cnt_q == 32'h0);
endmodule : pjog_tick
